// >>> rtl/adcsq_sequencer.sv
// Purpose: control of a 10-bit successive-approximation converter with APB registers
// Assumes: analog comparator outside, one state per pclk cycle
// Notes: 0x000 control/status, 0x004 trigger control, 0x008 edge select, 0x010.. data
// How it works
// - trigger enable bit 7 lets the trigger pin start conversions, edge chosen elsewhere
// - trigger control bits 6..1 read as ones
// - each result is built by successive approximation, ten bits
// - one write may set start together with new mode and channel
// - single mode converts the chosen channel once into its data register
// - end of single conversion sets end flag, interrupt if enabled
// - single mode start bit stays set, cleared at end, then idle
// - scan starts at first channel, converts up to four in turn
// - scan stores each channel result before moving on
// - after the group, end flag, interrupt if enabled, then restart group
// - scan never clears start itself; stops when start cleared
// - after start: delay, then sample, then convert
// - delay 6 or 4 states, sampling 31 or 15 states
// - first conversion totals 131..134 or 69..70 states
// - later scan conversions take 128 or 66 states
// - active trigger edge sets start, then same as software start
// - end flag clears only on zero write after reading it as one
// - speed bit picks slow or fast timing
// - channel field picks one input, or inputs 0..n in scan
// - scan runs until start cleared by software or reset
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "adcsq_params.svh"
module adcsq_sequencer (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog side
    input wire logic comparator_high,
    input wire logic external_conversion_trigger_pin,
    output logic [1:0] analog_channel,
    output logic [9:0] dac_code,
    output logic sample_hold,
    // interrupt request
    output logic conversion_end_interrupt
);
    adcsq_pkg::adcsq_regs_type q, d;
    logic cmp_s1_q, cmp_s2_q;

    // control/status as software reads it
    function automatic logic [7:0] rd_ctrl(input adcsq_pkg::adcsq_regs_type r);
        rd_ctrl = {r.end_flag, r.int_en, r.start, r.scan, r.speed, r.chsel};
    endfunction : rd_ctrl

    // trigger control as software reads it
    function automatic logic [7:0] rd_trig(input adcsq_pkg::adcsq_regs_type r);
        rd_trig = {r.trig_en, `ADCSQ_TRIG_RSVD_ONES, r.rsvd0};
    endfunction : rd_trig

    // start delay for the chosen speed
    function automatic logic [7:0] delay_len(input logic fast);
        if (fast) begin
            delay_len = `ADCSQ_DELAY_FAST;
        end else begin
            delay_len = `ADCSQ_DELAY_SLOW;
        end
    endfunction : delay_len

    // sampling window for the chosen speed
    function automatic logic [7:0] sample_len(input logic fast);
        if (fast) begin
            sample_len = `ADCSQ_SAMPLE_FAST;
        end else begin
            sample_len = `ADCSQ_SAMPLE_SLOW;
        end
    endfunction : sample_len

    // decision window; also sets the scan budget
    function automatic logic [7:0] conv_len(input logic fast);
        if (fast) begin
            conv_len = `ADCSQ_CONV_FAST;
        end else begin
            conv_len = `ADCSQ_CONV_SLOW;
        end
    endfunction : conv_len

    // fixed length of later scan conversions
    function automatic logic [7:0] next_len(input logic fast);
        if (fast) begin
            next_len = `ADCSQ_NEXT_FAST;
        end else begin
            next_len = `ADCSQ_NEXT_SLOW;
        end
    endfunction : next_len

    // only the three control registers take writes
    function automatic logic is_wr_reg(input logic [11:0] a);
        is_wr_reg = (a == `ADCSQ_OFF_CTRL_STATUS) || (a == `ADCSQ_OFF_TRIG_CTRL)
                    || (a == `ADCSQ_OFF_EDGE);
    endfunction : is_wr_reg

    // aligned result registers, read only
    function automatic logic is_data_reg(input logic [11:0] a);
        is_data_reg = (a >= `ADCSQ_OFF_DATA0) && (a <= `ADCSQ_OFF_DATA3)
                      && (a[1:0] == 2'h0);
    endfunction : is_data_reg

    // next channel of the group, back to the first after the last
    function automatic logic [1:0] next_chan(input logic [1:0] ch, input logic wrap);
        if (wrap) begin
            next_chan = 2'h0;
        end else begin
            next_chan = ch + 2'h1;
        end
    endfunction : next_chan

    // comparator is asynchronous to the clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= comparator_high;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    always_comb begin
        logic acc, wr, rd, trg_edge, last;
        logic [7:0] c;
        d = q;
        c = 8'h00;
        // answer registered in the first access cycle, write lands at the pready edge
        acc = psel && penable && !q.pready;
        wr = psel && penable && pwrite && q.pready;
        rd = acc && !pwrite;
        trg_edge = 1'b0;
        last = 1'b1;
        d.pready = acc;
        d.pslverr = 1'b0;
        // only the second trigger flop feeds the edge detector
        d.trg_sync = {q.trg_sync[0], external_conversion_trigger_pin};
        d.trg_prev = q.trg_sync[1];
        if (q.edge_rise) begin
            trg_edge = q.trg_sync[1] && !q.trg_prev;
        end else begin
            trg_edge = !q.trg_sync[1] && q.trg_prev;
        end
        if (q.scan) begin
            last = (q.chan == q.chsel[1:0]);
        end
        if (q.trig_en && trg_edge) begin
            d.start = 1'b1;
        end
        // sequencer
        unique case (q.st)
            adcsq_pkg::ST_IDLE: begin
                if (q.start) begin
                    d.st = adcsq_pkg::ST_DELAY;
                    d.cnt = delay_len(q.speed);
                    d.first = 1'b1;
                    if (q.scan) begin
                        d.chan = 2'h0;
                    end else begin
                        d.chan = q.chsel[1:0];
                    end
                end
            end
            adcsq_pkg::ST_DELAY: begin
                d.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    d.st = adcsq_pkg::ST_SAMPLE;
                    d.cnt = sample_len(q.speed);
                end
            end
            adcsq_pkg::ST_SAMPLE: begin
                d.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    d.st = adcsq_pkg::ST_CONVERT;
                    d.cnt = conv_len(q.speed);
                    d.sar = `ADCSQ_SAR_MID;
                    d.bitn = `ADCSQ_SAR_TOP;
                end
            end
            adcsq_pkg::ST_CONVERT: begin
                d.cnt = q.cnt - 8'h01;
                // every fourth cycle, so the comparator synchroniser has caught up
                c = conv_len(q.speed) - q.cnt;
                if (c[1:0] == 2'h3 && q.bitn != `ADCSQ_SAR_DONE) begin
                    if (!cmp_s2_q) begin
                        d.sar[q.bitn] = 1'b0;
                    end
                    if (q.bitn != 4'h0) begin
                        d.sar[q.bitn - 4'h1] = 1'b1;
                    end
                    d.bitn = q.bitn - 4'h1;
                end
                if (q.cnt == 8'h01) begin
                    d.st = adcsq_pkg::ST_STORE;
                end
            end
            adcsq_pkg::ST_STORE: begin
                d.data[q.chan] = q.sar;
                d.first = 1'b0;
                if (last) begin
                    d.end_flag = 1'b1;
                    d.end_seen = 1'b0;
                end
                if (!q.scan) begin
                    d.start = 1'b0;
                    d.st = adcsq_pkg::ST_IDLE;
                end else if (q.start) begin
                    d.chan = next_chan(q.chan, last);
                    d.st = adcsq_pkg::ST_SAMPLE;
                    // later conversions skip the delay and fit the fixed budget
                    c = next_len(q.speed) - conv_len(q.speed) - 8'h01;
                    d.cnt = c;
                end else begin
                    d.st = adcsq_pkg::ST_IDLE;
                end
            end
            default: begin
                d.st = adcsq_pkg::ST_IDLE;
            end
        endcase
        // clearing start aborts at the next edge; a result is still stored only if the store state is already reached
        if (q.st != adcsq_pkg::ST_IDLE && !q.start) begin
            d.st = adcsq_pkg::ST_IDLE;
        end
        // register writes
        if (wr) begin
            unique case (paddr)
                `ADCSQ_OFF_CTRL_STATUS: begin
                    // a set in this same cycle wins over the clear
                    if (!pwdata[`ADCSQ_BIT_END_FLAG] && q.end_seen && d.end_flag == q.end_flag
                        && !(q.st == adcsq_pkg::ST_STORE && last)) begin
                        d.end_flag = 1'b0;
                    end
                    d.int_en = pwdata[`ADCSQ_BIT_INT_EN];
                    d.start = pwdata[`ADCSQ_BIT_START] | (q.trig_en & trg_edge);
                    d.scan = pwdata[`ADCSQ_BIT_SCAN];
                    d.speed = pwdata[`ADCSQ_BIT_SPEED];
                    d.chsel = pwdata[`ADCSQ_CHSEL_MSB:0];
                end
                `ADCSQ_OFF_TRIG_CTRL: begin
                    d.trig_en = pwdata[`ADCSQ_BIT_TRIG_EN];
                    d.rsvd0 = pwdata[`ADCSQ_BIT_RSVD0];
                end
                `ADCSQ_OFF_EDGE: begin
                    d.edge_rise = pwdata[`ADCSQ_BIT_EDGE];
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            d.prdata = 32'h0000_0000;
            unique case (paddr)
                `ADCSQ_OFF_CTRL_STATUS: begin
                    d.prdata[7:0] = rd_ctrl(q);
                    if (q.end_flag) begin
                        d.end_seen = 1'b1;
                    end
                end
                `ADCSQ_OFF_TRIG_CTRL: begin
                    d.prdata[7:0] = rd_trig(q);
                end
                `ADCSQ_OFF_EDGE: begin
                    d.prdata[`ADCSQ_BIT_EDGE] = q.edge_rise;
                end
                default: begin
                    if (is_data_reg(paddr)) begin
                        d.prdata[9:0] = q.data[paddr[3:2]];
                    end else begin
                        d.pslverr = 1'b1;
                    end
                end
            endcase
        end else if (acc && pwrite && !is_wr_reg(paddr)) begin
            d.pslverr = 1'b1;
        end
        d.irq = d.end_flag && d.int_en;
        d.an_chan = d.chan;
        d.dac = d.sar;
        d.sh = (d.st == adcsq_pkg::ST_SAMPLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // every output straight from a flop
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign analog_channel = q.an_chan;
    assign dac_code = q.dac;
    assign sample_hold = q.sh;
    assign conversion_end_interrupt = q.irq;
endmodule : adcsq_sequencer

// >>> rtl/adcsq_params.svh
// Purpose: constants for the conversion sequencer
// Assumes: 25 MHz pclk, one state per pclk cycle
// Notes: register offsets are byte addresses on APB
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH
`define ADCSQ_OFF_CTRL_STATUS 12'h000
`define ADCSQ_OFF_TRIG_CTRL 12'h004
`define ADCSQ_OFF_EDGE 12'h008
`define ADCSQ_OFF_DATA0 12'h010
`define ADCSQ_OFF_DATA3 12'h01C
`define ADCSQ_BIT_END_FLAG 7
`define ADCSQ_BIT_INT_EN 6
`define ADCSQ_BIT_START 5
`define ADCSQ_BIT_SCAN 4
`define ADCSQ_BIT_SPEED 3
`define ADCSQ_BIT_TRIG_EN 7
`define ADCSQ_TRIG_RSVD_ONES 6'h3F
`define ADCSQ_BIT_RSVD0 0
`define ADCSQ_BIT_EDGE 0
`define ADCSQ_CHSEL_MSB 2
`define ADCSQ_SAR_MID 10'h200
`define ADCSQ_SAR_TOP 4'h9
`define ADCSQ_SAR_DONE 4'hF
`define ADCSQ_DELAY_SLOW 8'h06
`define ADCSQ_DELAY_FAST 8'h04
`define ADCSQ_SAMPLE_SLOW 8'h1F
`define ADCSQ_SAMPLE_FAST 8'h0F
`define ADCSQ_CONV_SLOW 8'h61
`define ADCSQ_CONV_FAST 8'h33
`define ADCSQ_NEXT_SLOW 8'h80
`define ADCSQ_NEXT_FAST 8'h42
`endif

// >>> rtl/adcsq_pkg.sv
// Purpose: types for the conversion sequencer
// Assumes: nothing
// Notes: state held as one packed struct
package adcsq_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT, ST_STORE} adcsq_state_type;
    typedef struct packed {
        adcsq_state_type st;
        logic [7:0] cnt;
        logic [1:0] chan;
        logic first;
        logic [9:0] sar;
        logic [3:0] bitn;
        logic end_flag;
        logic end_seen;
        logic int_en;
        logic start;
        logic scan;
        logic speed;
        logic [2:0] chsel;
        logic trig_en;
        logic rsvd0;
        logic edge_rise;
        logic [1:0] trg_sync;
        logic trg_prev;
        logic irq;
        logic [3:0][9:0] data;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] an_chan;
        logic [9:0] dac;
        logic sh;
    } adcsq_regs_type;
endpackage : adcsq_pkg

// >>> sim/adcsq_sequencer_props.sv
// Purpose: port checks for the sequencer
// Assumes: one wait state on apb
// Notes: bound to the design below
`timescale 1ns/1ps
`include "adcsq_params.svh"
module adcsq_sequencer_props (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // analog side
    input wire logic [1:0] analog_channel,
    input wire logic sample_hold,
    input wire logic conversion_end_interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mapped = paddr inside {`ADCSQ_OFF_CTRL_STATUS, `ADCSQ_OFF_TRIG_CTRL, `ADCSQ_OFF_EDGE}
        || (!pwrite && paddr inside {`ADCSQ_OFF_DATA0, 12'h014, 12'h018, `ADCSQ_OFF_DATA3});
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    chk_ready_wait: assert property (psel && $rose(penable) |=> pready) else $error("late pready");
    chk_err_decode: assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
    chk_err_alone: assert property (pslverr |-> pready) else $error("pslverr without pready");
    chk_rsvd_ones: assert property (
        pready && !pwrite && paddr == `ADCSQ_OFF_TRIG_CTRL |-> prdata[6:1] == 6'h3F)
        else $error("reserved bits not one");
    chk_sample_run: assert property ($rose(sample_hold) |-> sample_hold[*8])
        else $error("sampling too short");
    chk_convert_gap: assert property ($fell(sample_hold) |-> !sample_hold[*8])
        else $error("no conversion after sampling");
    chk_chan_hold: assert property (
        sample_hold && $past(sample_hold) |-> $stable(analog_channel))
        else $error("channel moved while sampling");
    chk_irq_clear: assert property ($fell(conversion_end_interrupt) |->
        $past(psel && pwrite, 1) || $past(psel && pwrite, 2)) else $error("irq fell alone");
    cover property ($rose(conversion_end_interrupt));
    cover property (pready && pslverr);
    cover property ($rose(sample_hold) && analog_channel == 2'h3);
endmodule : adcsq_sequencer_props
bind adcsq_sequencer adcsq_sequencer_props i_adcsq_sequencer_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_channel(analog_channel),
    .sample_hold(sample_hold), .conversion_end_interrupt(conversion_end_interrupt));

// >>> sim/adcsq_analog_model.sv
// Purpose: four analog inputs and a comparator
// Assumes: level lies half a step above its code
// Notes: held value frozen when sampling ends
`timescale 1ns/1ps
module adcsq_analog_model #(
    parameter logic [3:0][9:0] LEVELS = '0
) (
    // converter side
    input wire logic [1:0] analog_channel,
    input wire logic [9:0] dac_code,
    input wire logic sample_hold,
    output logic comparator_high
);
    logic [9:0] held = 10'h000;
    always @(analog_channel or sample_hold) begin
        if (sample_hold) begin
            held = LEVELS[analog_channel];
        end
    end
    // half step above: strict and loose compares agree
    assign comparator_high = (dac_code <= held);
endmodule : adcsq_analog_model

// >>> sim/adcsq_sequencer_tb_top.sv
// Purpose: self-checking bench for the sequencer
// Assumes: one wait state on apb
// Notes: inputs driven by nba at rising edges
`timescale 1ns/1ps
module adcsq_sequencer_tb_top;
    localparam logic [3:0][9:0] LVL = {10'h000, 10'h3FF, 10'h15A, 10'h2A5};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trg = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat, prdata;
    logic pready, pslverr, cmp, sh, irq, err;
    logic [1:0] chan;
    logic [9:0] dac;
    int fail_count = 0, total_checks = 0, cyc = 0, n;
    always #20 pclk = ~pclk;
    adcsq_sequencer i_adcsq_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comparator_high(cmp),
        .external_conversion_trigger_pin(trg), .analog_channel(chan), .dac_code(dac),
        .sample_hold(sh), .conversion_end_interrupt(irq));
    adcsq_analog_model #(.LEVELS(LVL)) i_adcsq_analog_model (.analog_channel(chan),
        .dac_code(dac), .sample_hold(sh), .comparator_high(cmp));
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task chk_range(input int v, input int lo, input int hi, input string m);
        total_checks++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("mismatch %0t %s took %0d", $time, m, v);
        end
    endtask : chk_range
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] exp, input string m);
        apb(0, a, 32'h0);
        chk(rdat, exp, m);
    endtask : rd
    task wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_irq
    task t_regs;
        rd(12'h000, 32'h00, "ctrl reset");
        rd(12'h004, 32'h7E, "trig reset");
        apb(1, 12'h004, 32'h80);
        rd(12'h004, 32'hFE, "trig enable");
        apb(0, 12'h020, 32'h0);
        chk(err, 1'b1, "unmapped");
        $display("regs done");
    endtask : t_regs
    task t_single;
        apb(1, 12'h000, 32'h6A);
        wait_irq();
        chk_range(n, 69, 73, "single fast");
        apb(1, 12'h000, 32'h48);
        rd(12'h000, 32'hC8, "flag kept");
        rd(12'h018, LVL[2], "single data");
        apb(1, 12'h000, 32'h48);
        rd(12'h000, 32'h48, "flag cleared");
        chk(irq, 1'b0, "irq cleared");
        $display("single done");
    endtask : t_single
    task t_scan;
        apb(1, 12'h008, 32'h0);
        apb(1, 12'h000, 32'h53);
        @(posedge pclk);
        trg <= 0;
        wait_irq();
        chk_range(n, 515, 528, "scan group");
        for (int i = 0; i < 4; i++) rd(12'h010 + 12'(4 * i), LVL[i], "scan data");
        rd(12'h000, 32'hF3, "scan status");
        apb(1, 12'h000, 32'h53);
        repeat (600) @(posedge pclk);
        rd(12'h000, 32'h53, "scan halted");
        chk(irq, 1'b0, "scan irq");
        $display("scan done");
    endtask : t_scan
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_single();
        t_scan();
        summarize();
    end
endmodule : adcsq_sequencer_tb_top
